// [core/rlo_defines.svh]
// Named constants for the receive line overhead monitor.
`ifndef RLO_DEFINES_SVH
`define RLO_DEFINES_SVH

`define RLO_ADDR_GLOBAL_LOAD 8'h00
`define RLO_ADDR_CTRL        8'h18
`define RLO_ADDR_INT         8'h19
`define RLO_ADDR_PAR_LOW     8'h1A
`define RLO_ADDR_PAR_MID     8'h1B
`define RLO_ADDR_PAR_HIGH    8'h1C
`define RLO_ADDR_REM_LOW     8'h1D
`define RLO_ADDR_REM_MID     8'h1E
`define RLO_ADDR_REM_HIGH    8'h1F

`define RLO_CTRL_BLOCK_MODE  7
`define RLO_CTRL_FORCE_ONES  6
`define RLO_CTRL_AIS_PERSIST 5
`define RLO_CTRL_RDI_PERSIST 4
`define RLO_CTRL_FEBE_GEN    3
`define RLO_CTRL_LSB         3
`define RLO_CTRL_RESET       5'h00

`define RLO_EN_LSB           4
`define RLO_EN_RESET         4'h0
`define RLO_FLAG_RDI         0
`define RLO_FLAG_AIS         1
`define RLO_FLAG_PARITY      2
`define RLO_FLAG_REMOTE      3
`define RLO_FLAG_RESET       4'h0

`define RLO_PAT_RDI          3'h6
`define RLO_PAT_AIS          3'h7
`define RLO_PERSIST_SHORT    3'h3
`define RLO_PERSIST_LONG     3'h5
`define RLO_RUN_ZERO         3'h0
`define RLO_RUN_ONE          3'h1

`define RLO_MAX_ERRS         5'h18
`define RLO_ERRS_ZERO        5'h00
`define RLO_ERRS_ONE         5'h01
`define RLO_CNT_MAX          20'hFFFFF
`define RLO_CNT_ZERO         20'h00000
`define RLO_BYTE_ZERO        8'h00
`define RLO_BYTE_ONES        8'hFF

`define RLO_CLK_PERIOD_NS    50
`define RLO_POLL_TIME_NS     2000
`define RLO_POLL_MAX_CYC     (`RLO_POLL_TIME_NS / `RLO_CLK_PERIOD_NS)

`endif

// [core/rlo_pkg.sv]
// Types shared by the receive line overhead monitor.
package rlo_pkg;
  typedef logic [19:0] rlo_cnt_t;

  typedef struct packed {
    logic       k2_valid;
    logic [2:0] k2_aps;
    logic       b2_valid;
    logic [4:0] b2_errs;
    logic       febe_valid;
    logic [4:0] febe_errs;
  } rlo_frame_s;
endpackage

// [core/rlo_rx_line_oh.sv]
// Receive line overhead monitor: alarms, error counters and register port.
//
// What this block does
// R1 - Mode bit one: one remote error report per frame having any parity error.
// R2 - Mode bit zero: one remote error report per parity bit error, max 24.
// R3 - Declare RDI after 110 in K2 bits 6-8 for 3 or 5 frames.
// R4 - Declare AIS after 111 in K2 bits 6-8 for 3 or 5 frames.
// R5 - Forcing bit set: data all ones while AIS declared, else pass.
// R6 - Forcing bit clear: recovered data never altered.
// R7 - Block mode counts one per errored frame, else every parity error.
// R8 - RDI state bit reads one while RDI is declared.
// R9 - AIS state bit reads one while AIS is declared.
// R10 - RDI and AIS change flags set on toggle, cleared on status read.
// R11 - Parity error flag set on any error, cleared on status read.
// R12 - Remote error flag set on received M0/M1 error, cleared on read.
// R13 - Enabled RDI and AIS changes raise an interrupt.
// R14 - Enabled parity and remote errors raise an interrupt.
// R15 - 20-bit parity error count readable as three bytes, low first.
// R16 - A write to any count address latches counts and restarts them.
// R17 - 20-bit remote error count readable as three bytes, low first.
// R18 - A poll latches the remote error count and restarts accumulation.
// R19 - A write to the global load address also latches both counts.
// R20 - Interrupt output high while any enabled flag is set.
// R21 - Accumulators saturate, and events coinciding with a poll are kept.
`timescale 1ns/1ps
`default_nettype none
`include "rlo_defines.svh"

module rlo_rx_line_oh (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  // Register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // Per-frame overhead results from the receive stream
  input  wire rlo_pkg::rlo_frame_s frame_i,
  // Recovered data path
  input  wire logic [7:0]        rx_data_i,
  output logic      [7:0]        rx_data_o,
  // Remote error reports toward the transmit line overhead block
  output logic                   tx_febe_valid_o,
  output logic      [4:0]        tx_febe_count_o,
  // Interrupt
  output logic                   int_o
);

  function automatic logic [4:0] clip_errs(input logic [4:0] e);
    clip_errs = (e > `RLO_MAX_ERRS) ? `RLO_MAX_ERRS : e;
  endfunction

  function automatic rlo_pkg::rlo_cnt_t sat_add(input rlo_pkg::rlo_cnt_t acc,
                                                 input logic [4:0] inc);
    logic [20:0] sum;
    sum = {1'b0, acc} + {16'h0000, inc};
    sat_add = sum[20] ? `RLO_CNT_MAX : sum[19:0];
  endfunction

  logic [1:0] match;
  logic [1:0] persist_short;
  logic [1:0] alarm_st;
  logic [1:0] alarm_chg;
  logic [4:0] ctrl_ff;

  assign match[0] = frame_i.k2_aps == `RLO_PAT_RDI;
  assign match[1] = frame_i.k2_aps == `RLO_PAT_AIS;
  assign persist_short[0] = ctrl_ff[`RLO_CTRL_RDI_PERSIST - `RLO_CTRL_LSB];
  assign persist_short[1] = ctrl_ff[`RLO_CTRL_AIS_PERSIST - `RLO_CTRL_LSB];

  // Entry 0 is RDI, entry 1 is AIS. Clearing uses the same persistence as
  // declaring, so a single corrupted K2 byte cannot drop a standing alarm.
  for (genvar g = 0; g < 2; g++) begin : g_alarm
    logic       alarm_ff;
    logic       nxt_alarm;
    logic [2:0] run_ff;
    logic [2:0] nxt_run;
    logic [2:0] need;

    always_comb begin
      need      = persist_short[g] ? `RLO_PERSIST_SHORT : `RLO_PERSIST_LONG;
      nxt_run   = run_ff;
      nxt_alarm = alarm_ff;
      if (frame_i.k2_valid) begin
        if (match[g] != alarm_ff) begin
          nxt_run = run_ff + `RLO_RUN_ONE;
          if (nxt_run >= need) begin
            nxt_alarm = match[g];  // [R3] [R4]
            nxt_run   = `RLO_RUN_ZERO;
          end
        end else begin
          nxt_run = `RLO_RUN_ZERO;
        end
      end
    end

    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        alarm_ff <= 1'b0;
        run_ff   <= `RLO_RUN_ZERO;
      end else begin
        alarm_ff <= nxt_alarm;
        run_ff   <= nxt_run;
      end
    end

    assign alarm_st[g]  = alarm_ff;
    assign alarm_chg[g] = nxt_alarm != alarm_ff;
  end

  // Control bits and interrupt enables, written over the register port.
  logic [4:0] nxt_ctrl;
  logic [3:0] en_ff;
  logic [3:0] nxt_en;
  logic       wr_ctrl;
  logic       wr_int;

  always_comb begin
    wr_ctrl  = reg_wr_i && (reg_addr_i == `RLO_ADDR_CTRL);
    wr_int   = reg_wr_i && (reg_addr_i == `RLO_ADDR_INT);
    nxt_ctrl = ctrl_ff;
    nxt_en   = en_ff;
    if (wr_ctrl) begin
      nxt_ctrl = reg_wdata_i[7:`RLO_CTRL_LSB];
    end
    if (wr_int) begin
      nxt_en = reg_wdata_i[7:`RLO_EN_LSB];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl_ff <= `RLO_CTRL_RESET;
      en_ff   <= `RLO_EN_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
      en_ff   <= nxt_en;
    end
  end

  // Per-frame events. Mode bits are taken with each frame result, so a
  // write to the control register only affects frames that follow it.
  logic       block_mode;
  logic       febe_per_frame;
  logic       force_ones;
  logic [4:0] b2_errs;
  logic [4:0] b2_inc;
  logic [4:0] rem_inc;
  logic       poll;
  logic       rd_status;

  always_comb begin
    block_mode     = ctrl_ff[`RLO_CTRL_BLOCK_MODE - `RLO_CTRL_LSB];
    febe_per_frame = ctrl_ff[`RLO_CTRL_FEBE_GEN - `RLO_CTRL_LSB];
    force_ones     = ctrl_ff[`RLO_CTRL_FORCE_ONES - `RLO_CTRL_LSB];
    b2_errs = frame_i.b2_valid ? clip_errs(frame_i.b2_errs) : `RLO_ERRS_ZERO;
    rem_inc = frame_i.febe_valid ? clip_errs(frame_i.febe_errs) : `RLO_ERRS_ZERO;
    b2_inc  = b2_errs;
    if (block_mode && (b2_errs != `RLO_ERRS_ZERO)) begin
      b2_inc = `RLO_ERRS_ONE;  // [R7]
    end
    poll      = reg_wr_i && ((reg_addr_i >= `RLO_ADDR_PAR_LOW &&
                              reg_addr_i <= `RLO_ADDR_REM_HIGH) ||
                             reg_addr_i == `RLO_ADDR_GLOBAL_LOAD);  // [R16] [R19]
    rd_status = reg_rd_i && (reg_addr_i == `RLO_ADDR_INT);
  end

  // Sticky event flags, bit 3 down to bit 0: remote error, parity error,
  // AIS change and RDI change.
  logic [3:0] flag_set;
  logic [3:0] flag_st;
  logic [3:0] nxt_flag_st;

  assign flag_set = {rem_inc != `RLO_ERRS_ZERO,  // [R12]
                     b2_errs != `RLO_ERRS_ZERO,  // [R11]
                     alarm_chg[1],               // [R10]
                     alarm_chg[0]};              // [R10]

  // An event in the reading cycle wins over the clear, so no event can slip
  // unseen between two status reads.
  for (genvar k = 0; k < 4; k++) begin : g_flag
    logic flag_ff;
    logic nxt_flag;

    always_comb begin
      nxt_flag = flag_ff;
      if (rd_status) begin
        nxt_flag = 1'b0;  // [R10] [R11] [R12]
      end
      if (flag_set[k]) begin
        nxt_flag = 1'b1;  // [R10] [R11] [R12]
      end
    end

    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        flag_ff <= 1'b0;
      end else begin
        flag_ff <= nxt_flag;
      end
    end

    assign flag_st[k]     = flag_ff;
    assign nxt_flag_st[k] = nxt_flag;
  end

  // Interrupt level, registered so that the pin comes from a flip-flop.
  logic int_ff;
  logic nxt_int;

  always_comb begin
    nxt_int = |(nxt_flag_st & nxt_en);  // [R13] [R14] [R20]
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      int_ff <= 1'b0;
    end else begin
      int_ff <= nxt_int;
    end
  end

  // Error counters: entry 0 counts parity errors, entry 1 received remote
  // errors. Each keeps a running accumulator and a copy latched by a poll.
  logic [1:0][4:0]           cnt_inc;
  rlo_pkg::rlo_cnt_t [1:0]   cnt_hold;

  assign cnt_inc[0] = b2_inc;   // [R7]
  assign cnt_inc[1] = rem_inc;

  for (genvar c = 0; c < 2; c++) begin : g_count
    rlo_pkg::rlo_cnt_t acc_ff;
    rlo_pkg::rlo_cnt_t nxt_acc;
    rlo_pkg::rlo_cnt_t hold_ff;
    rlo_pkg::rlo_cnt_t nxt_hold;

    // The frame's increment goes into the fresh accumulator on a poll, so
    // an error that coincides with the poll lands in the next period.
    always_comb begin
      nxt_hold = hold_ff;
      nxt_acc  = sat_add(acc_ff, cnt_inc[c]);  // [R21]
      if (poll) begin
        nxt_hold = acc_ff;  // [R16] [R18] [R19]
        nxt_acc  = sat_add(`RLO_CNT_ZERO, cnt_inc[c]);  // [R21]
      end
    end

    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        acc_ff  <= `RLO_CNT_ZERO;
        hold_ff <= `RLO_CNT_ZERO;
      end else begin
        acc_ff  <= nxt_acc;
        hold_ff <= nxt_hold;
      end
    end

    assign cnt_hold[c] = hold_ff;
  end

  // Remote error reports toward the transmit line overhead block.
  logic       febe_v_ff;
  logic       nxt_febe_v;
  logic [4:0] febe_c_ff;
  logic [4:0] nxt_febe_c;

  always_comb begin
    nxt_febe_c = b2_errs;  // [R2]
    if (febe_per_frame && (b2_errs != `RLO_ERRS_ZERO)) begin
      nxt_febe_c = `RLO_ERRS_ONE;  // [R1]
    end
    nxt_febe_v = nxt_febe_c != `RLO_ERRS_ZERO;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      febe_v_ff <= 1'b0;
      febe_c_ff <= `RLO_ERRS_ZERO;
    end else begin
      febe_v_ff <= nxt_febe_v;
      febe_c_ff <= nxt_febe_c;
    end
  end

  // Recovered data. Forcing follows the registered alarm, so the data turn
  // to all ones one cycle after the AIS state bit rises.
  logic [7:0] data_ff;
  logic [7:0] nxt_data;

  always_comb begin
    nxt_data = rx_data_i;  // [R6]
    if (force_ones && alarm_st[1]) begin
      nxt_data = `RLO_BYTE_ONES;  // [R5]
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      data_ff <= `RLO_BYTE_ZERO;
    end else begin
      data_ff <= nxt_data;
    end
  end

  // Read data stand for the one cycle after the strobe and are zero
  // otherwise, so a bus that ORs several blocks needs no extra select.
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = `RLO_BYTE_ZERO;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `RLO_ADDR_CTRL:     nxt_rdata = {ctrl_ff, 1'b0, alarm_st[1], alarm_st[0]};  // [R8] [R9]
        `RLO_ADDR_INT:      nxt_rdata = {en_ff, flag_st};
        `RLO_ADDR_PAR_LOW:  nxt_rdata = cnt_hold[0][7:0];  // [R15]
        `RLO_ADDR_PAR_MID:  nxt_rdata = cnt_hold[0][15:8];  // [R15]
        `RLO_ADDR_PAR_HIGH: nxt_rdata = {4'h0, cnt_hold[0][19:16]};  // [R15]
        `RLO_ADDR_REM_LOW:  nxt_rdata = cnt_hold[1][7:0];  // [R17]
        `RLO_ADDR_REM_MID:  nxt_rdata = cnt_hold[1][15:8];  // [R17]
        `RLO_ADDR_REM_HIGH: nxt_rdata = {4'h0, cnt_hold[1][19:16]};  // [R17]
        default:            nxt_rdata = `RLO_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_ff <= `RLO_BYTE_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o     = rdata_ff;
  assign rx_data_o       = data_ff;
  assign tx_febe_valid_o = febe_v_ff;
  assign tx_febe_count_o = febe_c_ff;
  assign int_o           = int_ff;

endmodule

`default_nettype wire

// [testbench/rlo_rx_line_oh_properties.sv]
// Port-level assertions for the receive line overhead monitor.
`timescale 1ns/1ps
`default_nettype none
module rlo_rx_line_oh_chk (
  // Clock and reset
  input wire logic                clock_i,
  input wire logic                sys_rst_i,
  // Register port
  input wire logic [7:0]          reg_addr_i,
  input wire logic                reg_wr_i,
  input wire logic                reg_rd_i,
  input wire logic [7:0]          reg_rdata_o,
  // Stream side
  input wire rlo_pkg::rlo_frame_s frame_i,
  input wire logic [7:0]          rx_data_i,
  input wire logic [7:0]          rx_data_o,
  input wire logic                tx_febe_valid_o,
  input wire logic [4:0]          tx_febe_count_o,
  input wire logic                int_o
);
  logic       rd_ff, err_ff, ev_ff;
  logic [7:0] a_ff, d_ff;
  // Inputs are held idle during reset, so these carry no stale events past it.
  always_ff @(posedge clock_i) begin
    rd_ff  <= reg_rd_i;
    a_ff   <= reg_addr_i;
    err_ff <= frame_i.b2_valid && (frame_i.b2_errs != 5'h00);
    ev_ff  <= reg_wr_i || frame_i.k2_valid || frame_i.b2_valid || frame_i.febe_valid;
    d_ff   <= rx_data_i;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  febe_cause_a: assert property (tx_febe_valid_o |-> err_ff)
    else $error("remote error report without a parity error");
  febe_issue_a: assert property (err_ff |-> tx_febe_valid_o)
    else $error("parity error frame not reported");
  febe_zero_a: assert property (!tx_febe_valid_o |-> tx_febe_count_o == 5'h00)
    else $error("report count nonzero while idle");
  febe_max_a: assert property (tx_febe_valid_o |-> tx_febe_count_o inside {[5'h01:5'h18]})
    else $error("report count out of range");
  data_pass_a: assert property (!$past(sys_rst_i) && rx_data_o != 8'hFF |-> rx_data_o == d_ff)
    else $error("recovered data altered");
  int_cause_a: assert property ($rose(int_o) |-> ev_ff || $past(ev_ff))
    else $error("interrupt rose without a cause");
  high_bits_a: assert property (rd_ff && (a_ff == 8'h1C || a_ff == 8'h1F)
    |-> reg_rdata_o[7:4] == 4'h0) else $error("count high byte upper bits set");
  rdata_idle_a: assert property (!rd_ff |-> reg_rdata_o == 8'h00)
    else $error("read data present without a read");
endmodule
bind rlo_rx_line_oh rlo_rx_line_oh_chk u_chk (.clock_i, .sys_rst_i, .reg_addr_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .frame_i, .rx_data_i, .rx_data_o, .tx_febe_valid_o,
  .tx_febe_count_o, .int_o);
`default_nettype wire

// [testbench/rlo_far_end.sv]
// Far-end line equipment model that hands over one overhead result per frame.
`timescale 1ns/1ps
`default_nettype none
module rlo_far_end (
  // Clock
  input  wire logic               clock_i,
  // Per-frame results
  output var rlo_pkg::rlo_frame_s frame_o
);
  initial frame_o = '0;
  // Idle fields show the inverse of the last frame, so stale values never pass for data.
  task automatic send(input logic [2:0] aps, input logic [4:0] b2, input logic [4:0] fe);
    @(posedge clock_i);
    frame_o <= {1'b1, aps, 1'b1, b2, 1'b1, fe};
    @(posedge clock_i);
    frame_o <= {1'b0, ~aps, 1'b0, ~b2, 1'b0, ~fe};
  endtask
endmodule
`default_nettype wire

// [testbench/tb_rx_line_overhead_monitor.sv]
// Self-checking bench for the receive line overhead monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_rx_line_overhead_monitor;
  logic clock_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_seen = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rx_data_i = 8'h00, d_prev = 8'h00;
  logic [7:0] reg_rdata_o, rx_data_o, rq[$];
  logic       tx_febe_valid_o, int_o;
  logic [4:0] tx_febe_count_o, e, f, fq[$];
  logic [19:0] par_cnt = 20'h00000, rem_cnt = 20'h00000;
  int n_mismatch = 0, cmp_count = 0;
  rlo_pkg::rlo_frame_s frame_i;
  initial forever #25 clock_i = ~clock_i;
  // The previous input byte is what the design registers at this edge.
  always @(posedge clock_i) begin
    d_prev    <= rx_data_i;
    rx_data_i <= 8'($urandom);
  end
  rlo_far_end u_far (.clock_i(clock_i), .frame_o(frame_i));
  rlo_rx_line_oh u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .frame_i(frame_i), .rx_data_i(rx_data_i),
    .rx_data_o(rx_data_o), .tx_febe_valid_o(tx_febe_valid_o),
    .tx_febe_count_o(tx_febe_count_o), .int_o(int_o));
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    rq.push_back(ex);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic frames(input int n, input logic [2:0] aps);
    repeat (n) u_far.send(aps, 5'h00, 5'h00);
  endtask
  task automatic int_is(input logic v);
    @(negedge clock_i);
    chk("int_o", {7'h00, v}, {7'h00, int_o});
  endtask
  // Results are taken at the falling edge, where every registered output has settled.
  always @(negedge clock_i) begin
    if (rd_seen) chk("reg_rdata_o", rq.pop_front(), reg_rdata_o);
    rd_seen = reg_rd_i;
    if (tx_febe_valid_o) chk("tx_febe_count_o", {3'h0, fq.pop_front()}, {3'h0, tx_febe_count_o});
  end
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    void'($urandom(29));
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (int a = 8'h18; a < 8'h20; a++) rd(8'(a), 8'h00);
    rd(8'h05, 8'h00);
    wr(8'h18, 8'h60);
    wr(8'h19, 8'h20);
    frames(3, 3'h7);
    rd(8'h18, 8'h62);
    @(negedge clock_i);
    chk("rx_data_o", 8'hFF, rx_data_o);
    int_is(1'b1);
    rd(8'h19, 8'h22);
    rd(8'h19, 8'h20);
    int_is(1'b0);
    frames(4, 3'h6);
    rd(8'h18, 8'h60);
    @(negedge clock_i);
    chk("rx_data_o", d_prev, rx_data_o);
    frames(1, 3'h6);
    rd(8'h18, 8'h61);
    rd(8'h19, 8'h23);
    wr(8'h18, 8'h10);
    frames(5, 3'h7);
    rd(8'h18, 8'h12);
    @(negedge clock_i);
    chk("rx_data_o", d_prev, rx_data_o);
    frames(5, 3'h0);
    rd(8'h19, 8'h23);
    wr(8'h19, 8'hF0);
    wr(8'h18, 8'h00);
    for (int i = 0; i < 7; i++) begin
      if (i == 4) wr(8'h18, 8'h88);
      e = 5'($urandom_range(24, 1));
      f = 5'($urandom_range(24, 1));
      par_cnt = par_cnt + ((i < 4) ? 20'(e) : 20'h00001);
      rem_cnt = rem_cnt + 20'(f);
      fq.push_back((i < 4) ? e : 5'h01);
      u_far.send(3'h0, e, f);
    end
    int_is(1'b1);
    wr(8'h1E, 8'h00);
    rd(8'h1A, par_cnt[7:0]);
    rd(8'h1B, par_cnt[15:8]);
    rd(8'h1C, {4'h0, par_cnt[19:16]});
    rd(8'h1D, rem_cnt[7:0]);
    rd(8'h1E, rem_cnt[15:8]);
    rd(8'h1F, {4'h0, rem_cnt[19:16]});
    rd(8'h19, 8'hFC);
    int_is(1'b0);
    fq.push_back(5'h01);
    u_far.send(3'h0, 5'h05, 5'h00);
    wr(8'h00, 8'h00);
    rd(8'h1A, 8'h01);
    rd(8'h1D, 8'h00);
    repeat (3) @(posedge clock_i);
    chk("pending", 8'h00, 8'(fq.size() + rq.size()));
    print_verdict();
  end
endmodule
`default_nettype wire
